/* File: logic/dac_host_pkg.sv */
package dac_host_pkg;
  // ****************************************
  // Word and link geometry
  // ****************************************
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int DEV_SEL_BITS = 2;
  localparam int NUM_DEVS = 4;
  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_MHZ = 25;
  localparam int SCLK_HALF_NS = 160;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int GAP_NS = 80;
  localparam int GAP_CYC = (GAP_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int DIV_BITS = 8;
  localparam logic [3:0] SEL_IDLE = 4'hf;
endpackage : dac_host_pkg

/* File: logic/dac_link_if.sv */
`timescale 1ns/100ps
interface dac_link_if;
  logic sclk;
  logic sdata;
  logic rise_tick;
  logic fall_tick;
  logic run;
  modport gen (input run, output sclk, output rise_tick, output fall_tick);
  modport ctl (output run, input sclk, input rise_tick, input fall_tick, output sdata);
endinterface : dac_link_if

/* File: logic/sclk_divider.sv */
`timescale 1ns/100ps
module sclk_divider
  import dac_host_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  dac_link_if.gen link // Clock and edge ticks
);
  logic [DIV_BITS-1:0] cnt;

  // Half-period counter; clock idles low when not running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      link.sclk <= 1'b0;
      link.rise_tick <= 1'b0;
      link.fall_tick <= 1'b0;
    end else if (!link.run) begin
      cnt <= '0;
      link.sclk <= 1'b0;
      link.rise_tick <= 1'b0;
      link.fall_tick <= 1'b0;
    end else if (cnt == DIV_BITS'(SCLK_HALF_CYC - 1)) begin
      cnt <= '0;
      link.sclk <= ~link.sclk;
      link.rise_tick <= ~link.sclk;
      link.fall_tick <= link.sclk;
    end else begin
      cnt <= cnt + 1'b1;
      link.rise_tick <= 1'b0;
      link.fall_tick <= 1'b0;
    end
  end
endmodule : sclk_divider

/* File: logic/dac_serial_host.sv */
`timescale 1ns/100ps
// Summary of operation
// - Host makes its own clock, active-low frame, 16-bit word, starts on load.
// - Host changes data on rising edge so it is stable at falling edge.
// - Clock idles low (polarity 0), data valid at falling edge (phase 1).
// - Frame select goes low before any data is sent.
// - Frame stays low between the two byte transfers of one word.
// - Frame rises after the second byte is fully sent, or early on an abort.
// - Word is sent most significant bit first, LSB-first input reversed.
// - Clock is driven so its falling edge is the device sampling point.
// - Only one of four device frame selects is low, via 2-to-4 decode.
// - Decoder enable inactive while the address changes.
module dac_serial_host
  import dac_host_pkg::*;
(
  input wire logic CLK_SYS, // System clock, 25 MHz
  input wire logic RST_N, // Async reset, active low
  input wire logic WR_VALID, // Word request
  input wire logic [WORD_BITS-1:0] WR_DATA, // Word to send
  input wire logic [DEV_SEL_BITS-1:0] WR_DEV, // Target device
  input wire logic WR_LSB_FIRST, // Data given LSB first
  input wire logic WR_ABORT, // Drop the frame early
  output logic WR_READY, // Idle, request accepted
  output logic WR_DONE, // One-cycle pulse per word end, none after an abort
  output logic SCLK, // Serial clock to devices
  output logic SDIN, // Serial data to devices
  output logic [NUM_DEVS-1:0] SYNC_N // Per-device frame select
);
  // ****************************************
  // State and storage
  // ****************************************
  typedef enum {S_IDLE, S_ADDR, S_FRAME, S_SHIFT, S_GAP, S_END} state_t;
  state_t state;
  logic [WORD_BITS-1:0] shreg;
  logic [DEV_SEL_BITS-1:0] dev;
  logic [4:0] bits_left;
  logic [7:0] wait_cnt;
  logic dec_enable;
  logic shreg_cnt_second;
  logic first_rise;
  logic abort_seen;
  dac_link_if link();

  // Reverse bit order of a word
  function automatic logic [WORD_BITS-1:0] reverse_bits(input logic [WORD_BITS-1:0] w);
    logic [WORD_BITS-1:0] r;
    r = '0;
    for (int i = 0; i < WORD_BITS; i++) begin
      r[i] = w[WORD_BITS-1-i];
    end
    return r;
  endfunction : reverse_bits

  // 2-to-4 decode with active-high enable, outputs active low
  function automatic logic [NUM_DEVS-1:0] decode_sel(input logic en, input logic [DEV_SEL_BITS-1:0] a);
    logic [NUM_DEVS-1:0] s;
    s = SEL_IDLE;
    if (en) begin
      s[a] = 1'b0;
    end
    return s;
  endfunction : decode_sel

  // ****************************************
  // Serial clock generator
  // ****************************************
  sclk_divider u_div (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .link(link.gen)
  );

  // Clock runs only while bits are shifted; idles low
  assign link.run = (state == S_SHIFT);

  // Top of the shift register is the bit on the line, MSB of the word first
  assign link.sdata = shreg[WORD_BITS-1];

  // ****************************************
  // Frame sequencer
  // ****************************************
  // Byte-wise framing keeps frame low across the gap between bytes
  // Wait states before the frame and before the clock give the decoder address
  // and the frame select time to settle; the cost is a few idle cycles per word
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state <= S_IDLE;
      shreg <= '0;
      dev <= '0;
      bits_left <= '0;
      wait_cnt <= '0;
      dec_enable <= 1'b0;
      WR_DONE <= 1'b0;
    end else begin
      WR_DONE <= 1'b0;
      case (state)
        S_IDLE: begin
          // Word is frozen here; later changes on the request pins are ignored
          if (WR_VALID) begin
            shreg <= WR_LSB_FIRST ? reverse_bits(WR_DATA) : WR_DATA;
            dev <= WR_DEV; // Address moves while enable is low
            wait_cnt <= 8'(GAP_CYC);
            state <= S_ADDR;
          end
        end
        S_ADDR: begin
          // Address settles before enable rises
          if (wait_cnt == 8'h00) begin
            dec_enable <= 1'b1; // Frame falls before any clock
            wait_cnt <= 8'(GAP_CYC);
            state <= S_FRAME;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        S_FRAME: begin
          if (wait_cnt == 8'h00) begin
            bits_left <= 5'(BYTE_BITS);
            state <= S_SHIFT;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        S_SHIFT: begin
          // Abort first, so no further bit follows a drop request
          // Limitation: an abort on the very last fall still leaves a full word
          if (WR_ABORT) begin
            state <= S_END; // Early frame rise, device discards
          end else if (link.fall_tick) begin
            // Device samples here next bit moves at rising edge
            if (bits_left == 5'h01) begin
              wait_cnt <= 8'(GAP_CYC);
              state <= (shreg_cnt_second) ? S_END : S_GAP;
            end
            bits_left <= bits_left - 1'b1;
          end else if (link.rise_tick && !first_rise) begin
            shreg <= {shreg[WORD_BITS-2:0], 1'b0}; // MSB first
          end
        end
        S_GAP: begin
          // Frame held low between the two bytes
          if (wait_cnt == 8'h00) begin
            bits_left <= 5'(BYTE_BITS);
            state <= S_SHIFT;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        S_END: begin
          // Frame rises after the last falling edge, then idle
          dec_enable <= 1'b0;
          WR_DONE <= !abort_seen;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Byte and first-edge tracking
  // ****************************************
  // Which byte is in flight; first rise of the word keeps the MSB on the line
  // First-rise flag set only in idle, so the second byte goes on shifting on every rise
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      shreg_cnt_second <= 1'b0;
      first_rise <= 1'b0;
      abort_seen <= 1'b0;
    end else if (state == S_IDLE) begin
      shreg_cnt_second <= 1'b0;
      first_rise <= 1'b1;
      abort_seen <= 1'b0;
    end else if (state == S_SHIFT) begin
      if (WR_ABORT) begin
        abort_seen <= 1'b1;
      end
      if (link.rise_tick) begin
        first_rise <= 1'b0;
      end
      if (link.fall_tick && bits_left == 5'h01) begin
        shreg_cnt_second <= 1'b1;
      end
    end
  end

  // ****************************************
  // Registered pins
  // ****************************************
  // Pins mirror internal state one cycle later so all outputs are flops
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      SCLK <= 1'b0;
      SDIN <= 1'b0;
    end else begin
      SCLK <= link.sclk;
      SDIN <= link.sdata; // Same delay as the clock keeps the phase
    end
  end

  // Frame selects from flopped enable and address, so the decode cannot glitch
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      SYNC_N <= SEL_IDLE;
    end else begin
      SYNC_N <= decode_sel(dec_enable, dev); // One device at a time
    end
  end

  // Ready drops on the edge that takes a request, the same edge on which the state leaves idle
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      WR_READY <= 1'b0;
    end else begin
      WR_READY <= (state == S_IDLE) && !WR_VALID;
    end
  end
endmodule : dac_serial_host

/* File: dv/dac_host_checker.sv */
`timescale 1ns/100ps
module dac_host_checker
  import dac_host_pkg::*;
(
  input wire logic CLK_SYS, // Clock
  input wire logic RST_N, // Reset
  input wire logic WR_VALID, // Request
  input wire logic WR_READY, // Idle
  input wire logic WR_DONE, // Word end
  input wire logic SCLK, // Serial clock
  input wire logic SDIN, // Serial data
  input wire logic [NUM_DEVS-1:0] SYNC_N // Frames
);
  // ****
  // Port timing
  // ****
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // High phase of the serial clock
  sequence s_high;
    SCLK [*4];
  endsequence
  chk_one_frame: assert property ($countones(~SYNC_N) <= 1) else $error("two frames low");
  chk_clk_high: assert property ($rose(SCLK) |-> s_high) else $error("bad clock high");
  chk_done_once: assert property (WR_DONE |=> !WR_DONE) else $error("long done");
  chk_done_idle: assert property (WR_DONE |-> ##[0:2] SYNC_N == SEL_IDLE) else $error("frame open");
  chk_data_held: assert property ($fell(SCLK) |-> $stable(SDIN)) else $error("data moved");
  chk_frame_clk: assert property (SCLK |-> SYNC_N != SEL_IDLE) else $error("clock unframed");
  chk_frame_hold: assert property (SCLK |-> $stable(SYNC_N)) else $error("frame moved");
  chk_idle_quiet: assert property (WR_READY |-> SYNC_N == SEL_IDLE && !SCLK) else $error("busy idle");
  chk_take: assert property (WR_VALID && WR_READY |=> !WR_READY) else $error("not taken");
  chk_sel_switch: assert property (!$stable(SYNC_N) |-> SYNC_N == SEL_IDLE || $past(SYNC_N) == SEL_IDLE)
    else $error("frame swapped");
endmodule : dac_host_checker

/* File: dv/dac_dev_model.sv */
`timescale 1ns/100ps
module dac_dev_model
  import dac_host_pkg::*;
(
  input wire logic SCLK, // Serial clock
  input wire logic SDIN, // Serial data
  input wire logic [NUM_DEVS-1:0] SYNC_N // Frames
);
  logic [WORD_BITS-1:0] input_reg [NUM_DEVS];
  logic [WORD_BITS-1:0] shift [NUM_DEVS];
  int cnt [NUM_DEVS];
  int updates = 0;
  // Shift on falls; extra clocks ignored, first bit ends at the top
  always @(negedge SCLK) begin
    for (int i = 0; i < NUM_DEVS; i++) begin
      if (SYNC_N[i] === 1'b0 && cnt[i] < WORD_BITS) begin
        shift[i] = {shift[i][WORD_BITS-2:0], SDIN};
        cnt[i]++;
      end
    end
  end
  // Short frames are dropped, full ones land in the channel register
  for (genvar g = 0; g < NUM_DEVS; g++) begin : g_dev
    initial input_reg[g] = '0;
    always @(SYNC_N[g]) begin
      if (SYNC_N[g] === 1'b1 && cnt[g] == WORD_BITS) begin
        input_reg[g] = shift[g];
        updates++;
      end
      cnt[g] = 0;
    end
  end
endmodule : dac_dev_model

/* File: dv/tb.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb;
  import dac_host_pkg::*;
  logic CLK_SYS, RST_N, WR_VALID, WR_LSB_FIRST, WR_ABORT, WR_READY, WR_DONE, SCLK, SDIN;
  logic [WORD_BITS-1:0] WR_DATA;
  logic [DEV_SEL_BITS-1:0] WR_DEV;
  logic [NUM_DEVS-1:0] SYNC_N;
  logic [WORD_BITS-1:0] exp_reg [NUM_DEVS];
  int failures = 0;
  int num_checks = 0;
  int dones = 0;
  int upd_seen = 0;
  dac_serial_host i_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .WR_VALID(WR_VALID), .WR_DATA(WR_DATA),
    .WR_DEV(WR_DEV), .WR_LSB_FIRST(WR_LSB_FIRST), .WR_ABORT(WR_ABORT), .WR_READY(WR_READY),
    .WR_DONE(WR_DONE), .SCLK(SCLK), .SDIN(SDIN), .SYNC_N(SYNC_N));
  dac_dev_model i_dev (.SCLK(SCLK), .SDIN(SDIN), .SYNC_N(SYNC_N));
  // ****
  // Clock and helpers
  // ****
  initial begin
    CLK_SYS = 0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) if (WR_DONE === 1'b1) dones <= dones + 1;
  task end_sim;
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic wait_ready;
    int n;
    // Let ready settle past the edge that may have just lowered it
    @(negedge CLK_SYS);
    n = 0;
    while (WR_READY !== 1'b1 && n < 400) begin
      @(negedge CLK_SYS);
      n++;
    end
    if (n >= 400) failures++;
  endtask : wait_ready
  // One word; abort lands mid-shift, well before the sixteenth fall
  task automatic send(input logic [WORD_BITS-1:0] d, input logic [DEV_SEL_BITS-1:0] dv, input logic lsb,
    input logic ab);
    int upd, dn;
    bit q[$];
    logic [WORD_BITS-1:0] w;
    upd = i_dev.updates;
    dn = dones;
    wait_ready();
    @(posedge CLK_SYS);
    WR_VALID <= 1'b1;
    WR_DATA <= d;
    WR_DEV <= dv;
    WR_LSB_FIRST <= lsb;
    @(posedge CLK_SYS);
    WR_VALID <= 1'b0;
    if (ab) begin
      repeat (40) @(posedge CLK_SYS);
      WR_ABORT <= 1'b1;
    end
    wait_ready();
    @(posedge CLK_SYS);
    WR_ABORT <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    if (!ab) begin
      // Line order of the bits; the first one on the line is the word's top bit, or its bit 0 when lsb is set
      for (int i = 0; i < WORD_BITS; i++) q.push_back(lsb ? d[i] : d[WORD_BITS-1-i]);
      w = '0;
      while (q.size() > 0) w = {w[WORD_BITS-2:0], q.pop_front()};
      exp_reg[dv] = w;
    end
    `CHK(i_dev.input_reg[dv], exp_reg[dv])
    `CHK(i_dev.updates - upd, int'(!ab))
    `CHK(dones - dn, int'(!ab))
  endtask : send
  // ****
  // Main sequence
  // ****
  initial begin
    RST_N = 0;
    WR_VALID = 0;
    WR_DATA = '0;
    WR_DEV = '0;
    WR_LSB_FIRST = 0;
    WR_ABORT = 0;
    foreach (exp_reg[i]) exp_reg[i] = '0;
    void'($urandom(32'h7d9f));
    repeat (6) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    send(16'h8001, 2'h0, 1'b0, 1'b0);
    send(16'h8003, 2'h1, 1'b1, 1'b0);
    // Every device, random bit order, back to back
    for (int i = 0; i < 8; i++) send(WORD_BITS'($urandom()), DEV_SEL_BITS'(i), 1'($urandom()), 1'b0);
    send(16'h5a5a, 2'h2, 1'b0, 1'b1);
    // Reset in mid-word: pins fall back to idle, the device keeps its old word
    upd_seen = i_dev.updates;
    @(posedge CLK_SYS);
    WR_VALID <= 1'b1;
    WR_DATA <= 16'h0f0f;
    WR_DEV <= 2'h1;
    @(posedge CLK_SYS);
    WR_VALID <= 1'b0;
    repeat (50) @(posedge CLK_SYS);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    `CHK({SCLK, SDIN, SYNC_N, WR_READY, WR_DONE}, {2'b00, SEL_IDLE, 2'b00})
    RST_N <= 1'b1;
    repeat (4) @(posedge CLK_SYS);
    `CHK(i_dev.updates - upd_seen, 0)
    `CHK(i_dev.input_reg[1], exp_reg[1])
    send(16'hffff, 2'h3, 1'b0, 1'b0);
    end_sim();
  end
  // Hang guard, well past twelve words
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    failures++;
    end_sim();
  end
endmodule : tb
bind dac_serial_host dac_host_checker i_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .WR_VALID(WR_VALID),
  .WR_READY(WR_READY), .WR_DONE(WR_DONE), .SCLK(SCLK), .SDIN(SDIN), .SYNC_N(SYNC_N));
